/* pfseq_pkg.sv */
/*
  package for the bubble power-fail sequencer: timing constants, state enum,
  carrier structs.
  assumes a 200 MHz controller clock.
*/
package pfseq_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned PWRUP_TIME_US   = 50;
  localparam int unsigned PWRDN_MAX_US    = 110;
  localparam int unsigned COIL_STOP_US    = 20;
  localparam int unsigned PWRUP_CYCLES    = (PWRUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PWRDN_CYCLES    = (PWRDN_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned COIL_STOP_CYCLES = (COIL_STOP_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W           = 16;
  localparam logic [1:0]  SYNC_RESET_VAL  = 2'h3;

  typedef enum logic [2:0] {
    ST_UNPOWERED,
    ST_POWERUP,
    ST_RUN,
    ST_COIL_STOP,
    ST_RESET_HOLD
  } seq_state_t;

  typedef struct packed {
    logic supply_fail_n;
    logic ext_reset_n;
  } seq_in_t;

  typedef struct packed {
    logic support_reset_n;
    logic coil_drive_en;
    logic powerup_busy;
    logic powerdown_busy;
  } seq_out_t;

endpackage

/* sync2.sv */
/*
  two flip-flop synchroniser for one level.
  assumes i_clock is the destination clock; reset value given by parameter.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (i_ce) begin
      nxt_state.meta = i_async;
      nxt_state.sync = state_ff.meta;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff <= '{meta: RESET_VAL, sync: RESET_VAL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sync = state_ff.sync;

endmodule

/* bubble_powerfail_sequencer.sv */
/*
  power-up / power-down sequencer of the bubble controller: watches
  supply_fail_n and the external reset, drives the support reset and
  gates the coil drive controls.
  assumes one 200 MHz clock; pins are asynchronous; abort is a one-cycle
  pulse from the command decoder on the same clock; coil_run_req and
  coil_phase_end come from the coil drive logic on the same clock.
*/
`timescale 1ns/1ps
// Function
// - A rising edge on supply_fail_n starts the internal power-up sequence.
// - Support reset stays low through the 50 us power-up and after it, until an abort clears the latch.
// - A falling edge on supply_fail_n or the external reset starts power-down.
// - With coils running, the coil drive stops at the phase boundary, or after 20 us at most, before support reset asserts.
// - The coil-stop phase runs only when the rotating field is on.
// - Power-down completes within 110 us of starting.
// - If supply_fail_n returns high during power-down the sequence stops at once, except in coil stop while the external reset is low.
// - A low external reset during power-up lets the sequence finish but holds support reset until it rises.
module bubble_powerfail_sequencer (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_supply_fail_n,
  input  wire logic i_ext_reset_n,
  input  wire logic i_abort,
  input  wire logic i_coil_run_req,
  input  wire logic i_coil_phase_end,
  output logic      o_support_reset_n,
  output logic      o_coil_drive_en,
  output logic      o_powerup_busy,
  output logic      o_powerdown_busy
);

  typedef struct packed {
    pfseq_pkg::seq_state_t        st;
    logic [pfseq_pkg::CNT_W-1:0]  cnt;
    pfseq_pkg::seq_in_t           prev;
    logic                         stuck;
    pfseq_pkg::seq_out_t          out;
  } seq_ff_t;

  seq_ff_t state_ff;
  seq_ff_t nxt_state;
  pfseq_pkg::seq_in_t pin_sync;

  localparam logic [pfseq_pkg::CNT_W-1:0] PWRUP_LAST  = pfseq_pkg::CNT_W'(pfseq_pkg::PWRUP_CYCLES - 1);
  localparam logic [pfseq_pkg::CNT_W-1:0] PWRDN_LAST  = pfseq_pkg::CNT_W'(pfseq_pkg::PWRDN_CYCLES - 1);
  localparam logic [pfseq_pkg::CNT_W-1:0] COIL_LAST   = pfseq_pkg::CNT_W'(pfseq_pkg::COIL_STOP_CYCLES - 1);
  localparam logic [pfseq_pkg::CNT_W-1:0] CNT_ONE     = pfseq_pkg::CNT_W'(1);

  // pins synchronised before any edge logic
  sync2 #(.RESET_VAL(1'b0)) u_sync_fail (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_supply_fail_n),
    .o_sync  (pin_sync.supply_fail_n)
  );

  sync2 #(.RESET_VAL(1'b0)) u_sync_rst (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_ext_reset_n),
    .o_sync  (pin_sync.ext_reset_n)
  );

  logic fail_rise;
  logic fail_fall;
  logic rst_fall;
  logic hold_reset;

  always_comb begin
    fail_rise  = pin_sync.supply_fail_n & ~state_ff.prev.supply_fail_n;
    fail_fall  = ~pin_sync.supply_fail_n & state_ff.prev.supply_fail_n;
    rst_fall   = ~pin_sync.ext_reset_n & state_ff.prev.ext_reset_n;
    hold_reset = 1'b0;
    nxt_state  = state_ff;
    nxt_state.prev = pin_sync;
    nxt_state.cnt  = state_ff.cnt + CNT_ONE;
    case (state_ff.st)
      pfseq_pkg::ST_UNPOWERED: begin
        hold_reset = 1'b1;
        if (fail_rise) begin
          nxt_state.st  = pfseq_pkg::ST_POWERUP;
          nxt_state.cnt = '0;
        end
      end
      pfseq_pkg::ST_POWERUP: begin
        hold_reset = 1'b1;
        if (fail_fall) begin
          nxt_state.st = pfseq_pkg::ST_UNPOWERED;
        end else if (state_ff.cnt == PWRUP_LAST) begin
          nxt_state.st = pfseq_pkg::ST_RUN;
        end
      end
      pfseq_pkg::ST_RUN: begin
        hold_reset = ~pin_sync.ext_reset_n | state_ff.stuck;
        if (fail_fall || rst_fall) begin
          nxt_state.cnt = '0;
          // coil stop only with the field on
          if (state_ff.out.coil_drive_en) begin
            nxt_state.st = pfseq_pkg::ST_COIL_STOP;
            // support reset waits for the coil stop
            hold_reset   = state_ff.stuck;
          end else begin
            nxt_state.st = pfseq_pkg::ST_RESET_HOLD;
          end
        end
      end
      pfseq_pkg::ST_COIL_STOP: begin
        // support reset stays released until the drive stops
        hold_reset = state_ff.stuck;
        if (pin_sync.supply_fail_n && !rst_fall && state_ff.prev.ext_reset_n && fail_rise) begin
          nxt_state.st = pfseq_pkg::ST_RUN;
        end else if (i_coil_phase_end || state_ff.cnt == COIL_LAST) begin
          nxt_state.st = pfseq_pkg::ST_RESET_HOLD;
        end
      end
      pfseq_pkg::ST_RESET_HOLD: begin
        hold_reset = 1'b1;
        if (fail_rise) begin
          nxt_state.st = pfseq_pkg::ST_RUN;
        end else if (state_ff.cnt == PWRDN_LAST) begin
          // power-down done: sleep until power returns
          if (pin_sync.supply_fail_n) begin
            nxt_state.st = pfseq_pkg::ST_RUN;
          end else begin
            nxt_state.st = pfseq_pkg::ST_UNPOWERED;
          end
        end
      end
      default: begin
        hold_reset   = 1'b1;
        nxt_state.st = pfseq_pkg::ST_UNPOWERED;
      end
    endcase

    if (state_ff.st != nxt_state.st && nxt_state.st == pfseq_pkg::ST_RUN
        && state_ff.st == pfseq_pkg::ST_POWERUP) begin
      nxt_state.stuck = 1'b1; // reset may stay latched after power-up until abort
    end
    if (i_abort) begin
      nxt_state.stuck = 1'b0;
    end
    if (state_ff.cnt == '1) begin
      nxt_state.cnt = state_ff.cnt;
    end

    nxt_state.out.support_reset_n = ~hold_reset;
    // drive stays on without a gap from run into coil stop
    nxt_state.out.coil_drive_en   = (nxt_state.st == pfseq_pkg::ST_RUN) & i_coil_run_req & ~hold_reset
                                    | (nxt_state.st == pfseq_pkg::ST_COIL_STOP);
    nxt_state.out.powerup_busy    = (nxt_state.st == pfseq_pkg::ST_POWERUP);
    nxt_state.out.powerdown_busy  = (nxt_state.st == pfseq_pkg::ST_COIL_STOP)
                                    | (nxt_state.st == pfseq_pkg::ST_RESET_HOLD);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff.st   <= pfseq_pkg::ST_UNPOWERED;
      state_ff.cnt  <= '0;
      state_ff.prev <= '0;
      state_ff.stuck <= 1'b0;
      state_ff.out  <= '0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  assign o_support_reset_n = state_ff.out.support_reset_n;
  assign o_coil_drive_en   = state_ff.out.coil_drive_en;
  assign o_powerup_busy    = state_ff.out.powerup_busy;
  assign o_powerdown_busy  = state_ff.out.powerdown_busy;

endmodule

/* pfseq_checker.sv */
/* assertions on the sequencer ports.
   assumes i_ce held high. */
`timescale 1ns/1ps
module pfseq_checker (
  input wire logic i_clock, i_rst_n, i_ce, i_supply_fail_n, i_ext_reset_n, i_abort,
  input wire logic i_coil_run_req, i_coil_phase_end,
  input wire logic o_support_reset_n, o_coil_drive_en, o_powerup_busy, o_powerdown_busy
);
  localparam logic [15:0] PU = 16'(pfseq_pkg::PWRUP_CYCLES);
  localparam logic [15:0] PD = 16'(pfseq_pkg::PWRDN_CYCLES + 1);
  logic [15:0] pu_ff;
  logic [15:0] pd_ff;
  always_ff @(posedge i_clock) begin
    pu_ff <= (i_rst_n && o_powerup_busy) ? pu_ff + 16'h1 : 16'h0;
    pd_ff <= (i_rst_n && o_powerdown_busy) ? pd_ff + 16'h1 : 16'h0;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence pup_end;
    $fell(o_powerup_busy) && i_ext_reset_n;
  endsequence
  sequence back_good;
    (o_powerdown_busy && !o_coil_drive_en && !i_supply_fail_n) ##1 i_supply_fail_n [*8];
  endsequence
  AST_PUP_RST: assert property (o_powerup_busy |-> !o_support_reset_n) else $error("pup rst");
  AST_PUP_LEN: assert property ($fell(o_powerup_busy) |-> pu_ff == PU) else $error("pup len");
  AST_PDN_MAX: assert property (pd_ff <= PD) else $error("pdn len");
  AST_PDN_ORDER: assert property ($fell(o_support_reset_n) && o_powerdown_busy |-> !o_coil_drive_en) else $error("order");
  AST_COIL_ONLY: assert property ($rose(o_powerdown_busy) && !o_coil_drive_en |-> ##[0:2] !o_support_reset_n) else $error("no coil");
  AST_PDN_STOP: assert property (back_good |-> !o_powerdown_busy) else $error("no stop");
  AST_EXT_HOLD: assert property ((!i_ext_reset_n && !o_coil_drive_en) [*8] |-> !o_support_reset_n) else $error("ext");
  AST_ABORT_REL: assert property (pup_end ##[0:2] i_abort |-> ##[1:3] o_support_reset_n) else $error("abort");
endmodule

/* pfseq_host.sv */
/* supply monitor and host model facing the sequencer.
   assumes rail states come from the bench; DLY is the rail-good delay. */
`timescale 1ns/1ps
module pfseq_host #(
  parameter int DLY = 40
) (
  input  wire logic i_clock, i_ok5, i_ok12, i_ext_reset_n, i_pup_busy,
  output logic      o_supply_fail_n, o_abort
);
  int   cnt = 0;
  logic busy_ff = 1'b0;
  logic ext_ff = 1'b0;
  initial {o_supply_fail_n, o_abort} = 2'h0;
  always @(posedge i_clock) begin
    cnt = (i_ok5 && i_ok12) ? ((cnt < DLY) ? cnt + 1 : cnt) : 0;
    o_supply_fail_n <= (cnt == DLY);
    // abort after every power-up or external reset release, only with reset high
    o_abort <= i_ext_reset_n && ((busy_ff && !i_pup_busy) || !ext_ff);
    busy_ff <= i_pup_busy;
    ext_ff <= i_ext_reset_n;
  end
endmodule

/* bubble_powerfail_sequencer_bench.sv */
/* self-checking bench for the sequencer.
   assumes checker and host model compiled first. */
`timescale 1ns/1ps
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", s, e, g); end end
module bubble_powerfail_sequencer_bench;
  typedef struct packed {logic ext; logic coil; logic pend; logic [15:0] lo; logic [15:0] hi;} row_t;
  logic clk = 1'b0, rst_n = 1'b0, ok5 = 1'b0, ok12 = 1'b1, ext_n = 1'b0, coil = 1'b0, pend = 1'b0;
  logic sup_n, abort, srst_n, drv, pub, pdb;
  int   n_mismatch = 0, comparisons = 0, n, k;
  row_t rows [3] = '{'{1'b0, 1'b1, 1'b1, 16'h0003, 16'h000c}, '{1'b1, 1'b1, 1'b0, 16'h0f9c, 16'h0fa4},
                     '{1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000}};
  always #2.5 clk = ~clk;
  pfseq_host pfseq_host_i (.i_clock(clk), .i_ok5(ok5), .i_ok12(ok12), .i_ext_reset_n(ext_n),
    .i_pup_busy(pub), .o_supply_fail_n(sup_n), .o_abort(abort));
  bubble_powerfail_sequencer bubble_powerfail_sequencer_i (.i_clock(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_supply_fail_n(sup_n), .i_ext_reset_n(ext_n), .i_abort(abort), .i_coil_run_req(coil),
    .i_coil_phase_end(pend), .o_support_reset_n(srst_n), .o_coil_drive_en(drv),
    .o_powerup_busy(pub), .o_powerdown_busy(pdb));
  task automatic waitv(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n == 30000) n_mismatch++;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    `CHK("rst_out", 4'h0, {srst_n, drv, pub, pdb})
    rst_n = 1'b1;
    ok5 = 1'b1;
    waitv(sup_n, 1'b1);
    waitv(pub, 1'b1);
    `CHK("pup_go", 1'b1, n < 8)
    waitv(pub, 1'b0);
    `CHK("pup_len", 1'b1, n > 9990 && n < 10010)
    repeat (20) @(negedge clk);
    `CHK("ext_hold", 1'b0, srst_n)
    ext_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("abort_rel", 1'b1, srst_n)
    foreach (rows[i]) begin
      coil = rows[i].coil;
      repeat (10) @(negedge clk);
      `CHK("drv_on", rows[i].coil, drv)
      if (rows[i].ext) ext_n = 1'b0;
      else ok12 = 1'b0;
      waitv(pdb, 1'b1);
      for (k = 0; drv === 1'b1 && k < 5000; k++) begin
        `CHK("rst_early", 1'b1, srst_n)
        pend = rows[i].pend && k == 2;
        @(negedge clk);
      end
      pend = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("rst_on", 1'b0, srst_n)
      `CHK("stop_len", 1'b1, k >= rows[i].lo && k <= rows[i].hi)
      waitv(pdb, 1'b0);
      `CHK("pdn_len", 1'b1, n + k + 2 <= 22001)
      ext_n = 1'b1;
      ok12 = 1'b1;
      if (!rows[i].ext) waitv(pub, 1'b1);
      waitv(pub, 1'b0);
      repeat (8) @(negedge clk);
      `CHK("rel_again", 1'b1, srst_n)
    end
    ok5 = 1'b0;
    waitv(pdb, 1'b1);
    repeat (3) @(negedge clk);
    `CHK("rst_now", 1'b0, srst_n)
    ok5 = 1'b1;
    waitv(sup_n, 1'b1);
    waitv(pdb, 1'b0);
    `CHK("pdn_quit", 1'b1, n < 8)
    end_of_test();
  end
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule
bind bubble_powerfail_sequencer pfseq_checker pfseq_checker_i (.i_clock, .i_rst_n, .i_ce, .i_supply_fail_n,
  .i_ext_reset_n, .i_abort, .i_coil_run_req, .i_coil_phase_end, .o_support_reset_n, .o_coil_drive_en,
  .o_powerup_busy, .o_powerdown_busy);
